/* hdl/bl_fifo.sv */
module bl_fifo
    import bl_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    // handshakes on both sides
    assign inReady  = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem[rdPtr_reg];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // occupancy
    always_comb
    begin
        count_next = count_reg;
        if (push && !pop)
            count_next = count_reg + 1'b1;
        else if (pop && !push)
            count_next = count_reg - 1'b1;
    end

    // pointers and level
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            count_reg <= count_next;
            if (push)
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
            if (pop)
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr_reg] <= inData;
    end

endmodule : bl_fifo

/* hdl/bl_pkg.sv */
package bl_pkg;

    // command bytes seen on the link
    localparam logic [7:0] CMD_RATE_VAR   = 8'hb5;
    localparam logic [7:0] CMD_RATE_HALF  = 8'hb7;
    localparam logic [7:0] CMD_BOOT_END   = 8'h01;
    localparam logic [7:0] END_CONFIRM    = 8'hd0;
    localparam logic [7:0] CMD_STATUS_RD  = 8'h70;

    // parameter bytes of the variable rate command
    localparam logic [7:0] VAR_PARAM_FAST = 8'h00;
    localparam logic [7:0] VAR_PARAM_SLOW = 8'h01;

    // parameter bytes of the half-duplex rate command
    localparam logic [7:0] HALF_PARAM_500K = 8'h08;
    localparam logic [7:0] HALF_PARAM_250K = 8'h07;

    // clock, link timing and buffer sizes
    localparam int CLK_HZ             = 25000000;
    localparam int OSC_TYP_MHZ        = 40;
    localparam int BYTE_GAP_MS        = 20;
    localparam int TURNAROUND_US      = 500;
    localparam int TURNAROUND_CYCLES  = (TURNAROUND_US * (CLK_HZ / 1000000));
    localparam int FIFO_DEPTH         = 16;
    localparam int BYTE_W             = 8;

    // bit rates the link can be told to run at
    typedef enum logic [2:0] {
        RATE_BOOT,
        RATE_230400,
        RATE_250000,
        RATE_460800,
        RATE_500000
    } bl_rate_e;

    localparam bl_rate_e RATE_RESET = RATE_BOOT;

    // current link configuration handed to the uart
    typedef struct packed {
        logic     halfDuplex;
        bl_rate_e rate;
    } bl_rate_s;

    // pending rate change held until the reply has left
    typedef struct packed {
        logic     valid;
        bl_rate_e rate;
    } bl_pend_s;

endpackage : bl_pkg

/* hdl/bl_rate_end_ctl.sv */
// Contract
// [R1] after the variable rate command and its parameter byte the device echoes the parameter byte.
// [R2] a rate change takes effect only once the confirmation byte has fully left at the old rate.
// [R3] variable rate parameter 01h gives 230400 or 250000 bps, 00h gives 460800 or 500000 bps, by duplex mode.
// [R4] after the half-duplex rate command and its parameter the device answers with the command byte.
// [R5] half-duplex rate parameter 08h gives 500000 bps, 07h gives 250000 bps, all others are reserved.
// [R6] boot end is the end command byte then a confirmation byte, answered by the end command byte.
// [R7] after the boot end exchange the device ignores every byte until reset.
// [R8] the programmer ends the session when reprogramming is done or before power is removed.
// [R9] the programmer leaves at least 20 ms between the bytes it sends.
// [R10] in half-duplex mode a party stops driving the shared pin within 500 us of finishing its send.
// [R11] a status read after a program or erase returns the status reflecting that operation.
// [R12] the programmer sends only 00h or 01h as the variable rate parameter.
// [R13] a reserved half-duplex rate parameter leaves the current rate unchanged after the reply.
module bl_rate_end_ctl
    import bl_pkg::*;
#(
    parameter int          DEPTH       = FIFO_DEPTH,
    parameter logic [7:0]  STATUS_CMD  = CMD_STATUS_RD
)
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              halfDuplexStrap,
    input  wire logic              rxValid,
    input  wire logic [BYTE_W-1:0] rxData,
    output logic                   rxReady,
    output logic                   txValid,
    output logic [BYTE_W-1:0]      txData,
    input  wire logic              txReady,
    input  wire logic              txDone,
    input  wire logic [BYTE_W-1:0] flashStatusValue,
    input  wire logic              progEraseDone,
    output bl_rate_s               rateCfg,
    output logic                   pinDriveEn,
    output logic                   bootEnded
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PARAM,
        ST_CONFIRM,
        ST_SEND,
        ST_WAIT_DONE,
        ST_HALT
    } bl_state_e;

    // width of the local fill level, one bit more than the buffer's address
    localparam int LW = $clog2(DEPTH) + 1;

    bl_state_e         state_reg;
    logic [BYTE_W-1:0] cmd_reg;
    logic [BYTE_W-1:0] reply_reg;
    bl_pend_s          pend_reg;
    bl_pend_s          pend_next;
    bl_rate_s          rate_reg;
    logic              strapTaken_reg;
    logic              txValid_reg;
    logic              drive_reg;
    logic              ended_reg;
    logic              endPending_reg;
    logic              progErase_reg;

    logic              bufValid;
    logic [BYTE_W-1:0] bufData;
    logic              bufReady;
    logic              fifoInReady;
    logic              rxReady_reg;
    logic              take;
    logic              bufPush;
    logic [LW-1:0]     level_reg;
    logic [LW-1:0]     level_next;
    logic [BYTE_W-1:0] statusSnap_reg;

    // receive buffer between the uart and the interpreter
    bl_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (DEPTH)
    ) u_rxbuf (
        .clk      (clk),
        .reset    (reset),
        .inValid  (rxValid && rxReady_reg),
        .inData   (rxData),
        .inReady  (fifoInReady),
        .outValid (bufValid),
        .outData  (bufData),
        .outReady (bufReady)
    );

    // byte written into the buffer this cycle
    assign bufPush = rxValid && rxReady_reg && fifoInReady;

    // local fill level, which the room flag checks along with the buffer's own ready
    always_comb
    begin
        level_next = level_reg;
        if (bufPush && !take)
            level_next = level_reg + 1'b1;
        else if (take && !bufPush)
            level_next = level_reg - 1'b1;
    end

    // fill level register
    always_ff @(posedge clk)
    begin
        if (reset)
            level_reg <= '0;
        else
            level_reg <= level_next;
    end

    // registered copy of the buffer's room, one cycle conservative
    always_ff @(posedge clk)
    begin
        if (reset)
            rxReady_reg <= 1'b0;
        else
            rxReady_reg <= fifoInReady && !(bufPush && level_reg == LW'(DEPTH-1));
    end

    // bytes are drained only while listening; the halt state swallows them all
    assign bufReady = (state_reg == ST_IDLE) || (state_reg == ST_PARAM) ||
                      (state_reg == ST_CONFIRM) || (state_reg == ST_HALT);  // [R7]
    assign take     = bufValid && bufReady;

    // duplex mode strap, caught once after reset release
    always_ff @(posedge clk)
    begin
        if (reset)
            strapTaken_reg <= 1'b0;
        else
            strapTaken_reg <= 1'b1;
    end

    // rate decode of a parameter byte for the pending command
    always_comb
    begin
        pend_next = '{valid: 1'b0, rate: RATE_RESET};
        if (cmd_reg == CMD_RATE_VAR)
        begin
            if (bufData == VAR_PARAM_SLOW)  // [R3]
                pend_next = '{valid: 1'b1, rate: rate_reg.halfDuplex ? RATE_250000 : RATE_230400};
            else if (bufData == VAR_PARAM_FAST)  // [R3]
                pend_next = '{valid: 1'b1, rate: rate_reg.halfDuplex ? RATE_500000 : RATE_460800};
        end
        else
        begin
            if (bufData == HALF_PARAM_500K)  // [R5]
                pend_next = '{valid: 1'b1, rate: RATE_500000};
            else if (bufData == HALF_PARAM_250K)  // [R5]
                pend_next = '{valid: 1'b1, rate: RATE_250000};
        end
    end

    // command sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg      <= ST_IDLE;
            cmd_reg        <= '0;
            reply_reg      <= '0;
            pend_reg       <= '{valid: 1'b0, rate: RATE_RESET};
            endPending_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    pend_reg       <= '{valid: 1'b0, rate: RATE_RESET};
                    endPending_reg <= 1'b0;
                    if (take)
                    begin
                        cmd_reg <= bufData;
                        if (bufData == CMD_RATE_VAR || bufData == CMD_RATE_HALF)
                            state_reg <= ST_PARAM;
                        else if (bufData == CMD_BOOT_END)
                            state_reg <= ST_CONFIRM;  // [R6]
                        else if (bufData == STATUS_CMD)
                        begin
                            reply_reg <= progErase_reg ? statusSnap_reg : flashStatusValue;  // [R11]
                            state_reg <= ST_SEND;
                        end
                    end
                end
                ST_PARAM:
                begin
                    if (take)
                    begin
                        // echo parameter for the variable command, command byte otherwise
                        reply_reg <= (cmd_reg == CMD_RATE_VAR) ? bufData : CMD_RATE_HALF;  // [R1] [R4]
                        pend_reg  <= pend_next;  // [R12] [R13]
                        state_reg <= ST_SEND;
                    end
                end
                ST_CONFIRM:
                begin
                    if (take)
                    begin
                        if (bufData == END_CONFIRM)
                        begin
                            reply_reg      <= CMD_BOOT_END;  // [R6]
                            endPending_reg <= 1'b1;
                            state_reg      <= ST_SEND;
                        end
                        else
                            state_reg <= ST_IDLE;
                    end
                end
                ST_SEND:
                begin
                    if (txValid_reg && txReady)
                        state_reg <= ST_WAIT_DONE;
                end
                ST_WAIT_DONE:
                begin
                    if (txDone)
                        state_reg <= endPending_reg ? ST_HALT : ST_IDLE;  // [R7] [R8]
                end
                ST_HALT:
                begin
                    state_reg <= ST_HALT;  // [R7]
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // transmit request toward the uart
    always_ff @(posedge clk)
    begin
        if (reset)
            txValid_reg <= 1'b0;
        else if (txValid_reg && txReady)
            txValid_reg <= 1'b0;
        else if (state_reg == ST_SEND)
            txValid_reg <= 1'b1;
    end

    // link rate, switched only when the reply has fully left
    always_ff @(posedge clk)
    begin
        if (reset)
            rate_reg <= '{halfDuplex: 1'b0, rate: RATE_RESET};
        else
        begin
            if (!strapTaken_reg)
                rate_reg.halfDuplex <= halfDuplexStrap;
            if (state_reg == ST_WAIT_DONE && txDone && pend_reg.valid)
                rate_reg.rate <= pend_reg.rate;  // [R2] [R13]
        end
    end

    // shared pin drive, released the cycle after the last stop bit
    always_ff @(posedge clk)
    begin
        if (reset)
            drive_reg <= 1'b0;
        else if (state_reg == ST_WAIT_DONE && txDone)
            drive_reg <= 1'b0;  // [R10]
        else if (state_reg == ST_SEND && rate_reg.halfDuplex)
            drive_reg <= 1'b1;
    end

    // session end flag
    always_ff @(posedge clk)
    begin
        if (reset)
            ended_reg <= 1'b0;
        else if (state_reg == ST_WAIT_DONE && txDone && endPending_reg)
            ended_reg <= 1'b1;  // [R7]
    end

    // remembers that a program or erase finished, for a later status read
    always_ff @(posedge clk)
    begin
        if (reset)
            progErase_reg <= 1'b0;
        else if (progEraseDone)
            progErase_reg <= 1'b1;  // [R11]
        else if (take && state_reg == ST_IDLE && bufData == STATUS_CMD)
            progErase_reg <= 1'b0;
    end

    // status caught when a program or erase finishes, returned by the next status read
    always_ff @(posedge clk)
    begin
        if (reset)
            statusSnap_reg <= '0;
        else if (progEraseDone)
            statusSnap_reg <= flashStatusValue;  // [R11]
    end

    assign rxReady    = rxReady_reg;
    assign txValid    = txValid_reg;
    assign txData     = reply_reg;
    assign rateCfg    = rate_reg;
    assign pinDriveEn = drive_reg;
    assign bootEnded  = ended_reg;

endmodule : bl_rate_end_ctl

/* verif/bl_prog_model.sv */
module bl_prog_model
    import bl_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [7:0]        lag,
    input  wire logic              txValid,
    input  wire logic [BYTE_W-1:0] txData,
    output logic                   txReady,
    output logic                   txDone,
    output logic [BYTE_W-1:0]      gotByte,
    output int                     gotCount
);
    timeunit 1ns;
    timeprecision 1ns;
    int waitCnt;
    int sendCnt;

    // take reply after lag cycles, stop bits leave later
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            txReady  <= 1'b0;
            txDone   <= 1'b0;
            gotByte  <= 8'h00;
            gotCount <= 0;
            waitCnt  <= 0;
            sendCnt  <= 0;
        end
        else
        begin
            txReady <= 1'b0;
            txDone  <= (sendCnt == 1);
            if (sendCnt > 0)
                sendCnt <= sendCnt - 1;
            if (txValid && txReady)
            begin
                gotByte  <= txData;
                gotCount <= gotCount + 1;
                sendCnt  <= int'(lag) + 3;
                waitCnt  <= 0;
            end
            else if (txValid && sendCnt == 0)
            begin
                txReady <= (waitCnt >= int'(lag));
                waitCnt <= waitCnt + 1;
            end
        end
    end
endmodule : bl_prog_model

/* verif/bl_rate_end_ctl_assertions.sv */
module bl_rate_end_ctl_assertions
    import bl_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              halfDuplexStrap,
    input wire logic              rxValid,
    input wire logic [BYTE_W-1:0] rxData,
    input wire logic              rxReady,
    input wire logic              txValid,
    input wire logic [BYTE_W-1:0] txData,
    input wire logic              txReady,
    input wire logic              txDone,
    input wire logic [BYTE_W-1:0] flashStatusValue,
    input wire logic              progEraseDone,
    input wire bl_rate_s          rateCfg,
    input wire logic              pinDriveEn,
    input wire logic              bootEnded
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // reply handshake
    property p_tx_hold;
        txValid && !txReady |=> txValid && $stable(txData);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("reply not held");
    property p_tx_fall;
        txValid && txReady |=> !txValid;
    endproperty
    a_tx_fall: assert property (p_tx_fall)
        else $error("reply repeated");
    // rate moves only after the reply has left
    property p_rate_hold;
        !txDone |=> $stable(rateCfg.rate);
    endproperty
    a_rate_hold: assert property (p_rate_hold)
        else $error("rate changed early");
    // shared pin ownership
    property p_pin_release;
        txDone |=> !pinDriveEn;
    endproperty
    a_pin_release: assert property (p_pin_release)
        else $error("pin kept");
    property p_pin_mode;
        pinDriveEn |-> rateCfg.halfDuplex;
    endproperty
    a_pin_mode: assert property (p_pin_mode)
        else $error("pin driven in full duplex");
    property p_pin_when_tx;
        txValid && rateCfg.halfDuplex |-> pinDriveEn;
    endproperty
    a_pin_when_tx: assert property (p_pin_when_tx)
        else $error("pin not driven");
    // session end
    property p_end_cause;
        $rose(bootEnded) |-> $past(txDone);
    endproperty
    a_end_cause: assert property (p_end_cause)
        else $error("end without reply");
    property p_end_keep;
        bootEnded |=> bootEnded && !txValid && $stable(rateCfg.rate);
    endproperty
    a_end_keep: assert property (p_end_keep)
        else $error("active after end");

    // main scenarios reached
    c_reply: cover property (txValid && txReady);
    c_end: cover property ($rose(bootEnded));
    c_pin: cover property ($rose(pinDriveEn));
    c_full: cover property (!rxReady);
endmodule : bl_rate_end_ctl_assertions

bind bl_rate_end_ctl bl_rate_end_ctl_assertions bl_rate_end_ctl_assertions_inst (.clk, .reset, .halfDuplexStrap,
    .rxValid, .rxData, .rxReady, .txValid, .txData, .txReady, .txDone, .flashStatusValue, .progEraseDone,
    .rateCfg, .pinDriveEn, .bootEnded);

/* verif/tb.sv */
module tb
    import bl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk;
    logic                 reset;
    logic                 halfDuplexStrap;
    logic                 rxValid;
    logic                 rxReady;
    logic                 txValid;
    logic                 txReady;
    logic                 txDone;
    logic                 progEraseDone;
    logic                 pinDriveEn;
    logic                 bootEnded;
    logic [BYTE_W-1:0]    rxData;
    logic [BYTE_W-1:0]    txData;
    logic [BYTE_W-1:0]    flashStatusValue;
    logic [BYTE_W-1:0]    gotByte;
    logic [7:0]           lag;
    bl_rate_s             rateCfg;
    int                   gotCount;
    int                   nFail;
    int                   checkCount;
    logic [7:0]           resvParam [4] = '{8'h00, 8'h06, 8'h09, 8'hff};

    bl_rate_end_ctl bl_rate_end_ctl_inst (.clk, .reset, .halfDuplexStrap, .rxValid, .rxData, .rxReady,
        .txValid, .txData, .txReady, .txDone, .flashStatusValue, .progEraseDone, .rateCfg, .pinDriveEn, .bootEnded);
    bl_prog_model bl_prog_model_inst (.clk, .reset, .lag, .txValid, .txData, .txReady, .txDone, .gotByte, .gotCount);

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task end_sim();
        $display("checks %0d, errors %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task chk(input logic ok, input string msg);
        checkCount++;
        if (ok !== 1'b1)
        begin
            nFail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task do_reset(input logic hd);
        reset = 1'b1;
        halfDuplexStrap = hd;
        tick(6);
        reset = 1'b0;
        tick(2);
    endtask : do_reset

    task send_byte(input logic [7:0] b);
        int n;
        rxValid = 1'b1;
        rxData = b;
        n = 0;
        while (rxReady !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        chk(n < 200, "byte refused");
        tick(1);
        rxValid = 1'b0;
        tick(1);
    endtask : send_byte

    // wait for the reply, then for its last stop bit
    task finish(input int c0, input logic [7:0] expByte, input bl_rate_e expRate);
        int n;
        bl_rate_e oldRate;
        oldRate = rateCfg.rate;
        n = 0;
        while (gotCount == c0 && n < 300)
        begin
            tick(1);
            n++;
        end
        chk(n < 300, "no reply");
        chk(gotByte === expByte, "reply byte");
        chk(rateCfg.rate === oldRate, "rate moved early");
        chk(pinDriveEn === rateCfg.halfDuplex, "pin ownership");
        n = 0;
        while (txDone !== 1'b1 && n < 300)
        begin
            tick(1);
            n++;
        end
        chk(n < 300, "reply never left");
        tick(1);
        chk(rateCfg.rate === expRate, "rate after reply");
        chk(pinDriveEn === 1'b0, "pin not released");
    endtask : finish

    task exch(input logic [7:0] b0, b1, input logic two, input logic [7:0] expByte, input bl_rate_e expRate);
        int c0;
        c0 = gotCount;
        send_byte(b0);
        if (two)
            send_byte(b1);
        finish(c0, expByte, expRate);
    endtask : exch

    // buffer fills while the programmer stalls the reply
    task fill_test();
        int c0;
        int n;
        lag = 8'd80;
        c0 = gotCount;
        send_byte(CMD_RATE_HALF);
        send_byte(HALF_PARAM_250K);
        n = 0;
        while (rxReady === 1'b1 && n < 20)
        begin
            send_byte(8'h33);
            n++;
        end
        chk(n >= FIFO_DEPTH - 1 && n <= FIFO_DEPTH, "buffer depth");
        finish(c0, CMD_RATE_HALF, RATE_250000);
        lag = 8'd0;
        tick(60);
        chk(rxReady === 1'b1, "buffer not drained");
    endtask : fill_test

    initial
    begin
        #(40 * 20000);
        nFail++;
        end_sim;
    end

    initial
    begin
        int c0;
        nFail = 0;
        checkCount = 0;
        rxValid = 1'b0;
        rxData = 8'h00;
        flashStatusValue = 8'h00;
        progEraseDone = 1'b0;
        lag = 8'd0;
        do_reset(1'b0);
        chk(rateCfg === bl_rate_s'{1'b0, RATE_BOOT} && rxReady === 1'b1, "reset state");
        exch(CMD_RATE_VAR, VAR_PARAM_SLOW, 1'b1, VAR_PARAM_SLOW, RATE_230400);
        lag = 8'd9;
        exch(CMD_RATE_VAR, VAR_PARAM_FAST, 1'b1, VAR_PARAM_FAST, RATE_460800);
        lag = 8'd0;
        exch(CMD_RATE_HALF, HALF_PARAM_500K, 1'b1, CMD_RATE_HALF, RATE_500000);
        exch(CMD_RATE_HALF, HALF_PARAM_250K, 1'b1, CMD_RATE_HALF, RATE_250000);
        foreach (resvParam[i])
            exch(CMD_RATE_HALF, resvParam[i], 1'b1, CMD_RATE_HALF, RATE_250000);
        fill_test();
        flashStatusValue = 8'h5a;
        progEraseDone = 1'b1;
        tick(1);
        progEraseDone = 1'b0;
        flashStatusValue = 8'h3c;
        exch(CMD_STATUS_RD, 8'h00, 1'b0, 8'h5a, RATE_250000);
        exch(CMD_STATUS_RD, 8'h00, 1'b0, 8'h3c, RATE_250000);
        c0 = gotCount;
        send_byte(CMD_BOOT_END);
        send_byte(8'h55);
        tick(40);
        chk(gotCount == c0 && bootEnded === 1'b0, "end without confirm");
        do_reset(1'b1);
        chk(rateCfg === bl_rate_s'{1'b1, RATE_BOOT}, "strap");
        exch(CMD_RATE_HALF, HALF_PARAM_500K, 1'b1, CMD_RATE_HALF, RATE_500000);
        exch(CMD_RATE_VAR, VAR_PARAM_SLOW, 1'b1, VAR_PARAM_SLOW, RATE_250000);
        exch(CMD_RATE_VAR, VAR_PARAM_FAST, 1'b1, VAR_PARAM_FAST, RATE_500000);
        exch(CMD_BOOT_END, END_CONFIRM, 1'b1, CMD_BOOT_END, RATE_500000);
        chk(bootEnded === 1'b1, "not ended");
        c0 = gotCount;
        send_byte(CMD_RATE_VAR);
        send_byte(VAR_PARAM_SLOW);
        tick(100);
        chk(gotCount == c0 && bootEnded === 1'b1 && rateCfg.rate === RATE_500000, "active after end");
        do_reset(1'b0);
        chk(bootEnded === 1'b0 && rateCfg.rate === RATE_BOOT, "reset after end");
        end_sim;
    end
endmodule : tb
